/* File: hdl/station_cmd_defines.svh */
// Purpose: constants for the remote station command handler
// Assumes: included by the design module, the assertions and the bench
// Notes:   character codes, field sizes, reset values and timing counts only
`ifndef STATION_CMD_DEFINES_SVH
`define STATION_CMD_DEFINES_SVH

// =====================================================
// framing characters and replies
`define CH_QUERY         8'h3F
`define CH_PARAM         8'h24
`define CH_TERM          8'h0D
`define CH_LOWER_A       8'h61
`define CH_UPPER_A       8'h41
`define CH_DIGIT_0       8'h30
`define REPLY_ACK        8'h06
`define REPLY_NAK        8'h15

// =====================================================
// field sizes and reset values
`define SECRET_BYTES     8
`define PW_RESET_BASE    8'h31
`define ACODE_RESET      64'h3030303030303030
`define ERR_CLEAR        8'h00
`define ATTEMPTS_RESET   4'h3
`define QUERY_ITEMS      15

// =====================================================
// timing
`define WAIT_PERIOD_MIN  30
`define SEC_PER_MIN      60
`define CLK_HZ           50000000

`endif

/* File: hdl/station_cmd_pkg.sv */
// Purpose: shared types for the remote station command handler
// Assumes: nothing beyond the defines header
// Notes:   types only; numbers live in the header
package station_cmd_pkg;

    // =====================================================
    // modes, sequencer states and command kinds
    typedef enum logic [1:0] {MODE_STANDBY, MODE_COMMAND, MODE_TRANSPARENT} mode_t;
    typedef enum logic [1:0] {FX_IDLE, FX_CALL, FX_WAIT, FX_PAUSE} fax_state_t;
    typedef enum logic [2:0] {CK_NONE, CK_QUERY, CK_AUTH, CK_WRITE, CK_ACODE, CK_SWITCH} cmd_kind_t;

    // =====================================================
    // event carriers
    typedef struct packed {
        logic        valid;
        logic [3:0]  item;
    } query_evt_t;

    typedef struct packed {
        logic        valid;
        logic [4:0]  item;
        logic [31:0] args;
    } write_evt_t;

    typedef struct packed {
        logic        req;
        logic [1:0]  action;
        logic [1:0]  input_no;
    } call_req_t;

endpackage

/* File: hdl/remote_station_command_handler.sv */
// Purpose: command/transparent handler with spontaneous fax call sequencer
// Assumes: byte streams arrive on clk; link and signalling pins are async
// Notes:   relay paths store nothing beyond one register stage
`include "station_cmd_defines.svh"

module remote_station_command_handler #(
    parameter int CLK_HZ   = `CLK_HZ,
    parameter int WAIT_MIN = `WAIT_PERIOD_MIN
) (
    input  wire logic                            clk,
    input  wire logic                            rst,
    input  wire logic                            link_up,
    input  wire logic                            link_err,
    input  wire logic [1:0]                      caller_station,
    input  wire logic                            rx_valid,
    input  wire logic [7:0]                      rx_data,
    output logic                                 tx_valid,
    output logic [7:0]                           tx_data,
    input  wire logic                            term_rx_valid,
    input  wire logic [7:0]                      term_rx_data,
    output logic                                 term_tx_valid,
    output logic [7:0]                           term_tx_data,
    output logic                                 term_sel,
    output station_cmd_pkg::mode_t               mode,
    output station_cmd_pkg::query_evt_t          query_evt,
    output station_cmd_pkg::write_evt_t          write_evt,
    input  wire logic [7:0]                      fault_code,
    input  wire logic                            fault_set,
    output logic [7:0]                           err_status,
    input  wire logic [7:0]                      sig_level,
    output station_cmd_pkg::call_req_t           call,
    input  wire logic                            call_done,
    input  wire logic                            call_ok
);

    // =====================================================
    // elaboration checks
    localparam int SEC_CYCLES = CLK_HZ;
    localparam int WAIT_SEC   = WAIT_MIN * `SEC_PER_MIN;
    initial begin
        if (CLK_HZ < 2 || CLK_HZ > 67108864 || WAIT_MIN < 1 || WAIT_SEC >= 65536)
            $error("unsupported clock rate or wait period");
    end

    // classify a received two-character command
    function automatic station_cmd_pkg::cmd_kind_t classify(input logic [7:0] c0, input logic [7:0] c1);
        classify = station_cmd_pkg::CK_NONE;
        if (c0 == `CH_QUERY && c1 >= `CH_LOWER_A && c1 < `CH_LOWER_A + 8'(`QUERY_ITEMS))
            classify = station_cmd_pkg::CK_QUERY;
        else if (c0 == `CH_PARAM) begin
            case (c1)
                "A":     classify = station_cmd_pkg::CK_AUTH;
                "K":     classify = station_cmd_pkg::CK_ACODE;
                "N":     classify = station_cmd_pkg::CK_SWITCH;
                "B", "C", "D", "E", "F", "G", "H", "I", "J", "L", "M", "O", "P", "Q", "R", "S", "T":
                         classify = station_cmd_pkg::CK_WRITE;
                default: classify = station_cmd_pkg::CK_NONE;
            endcase
        end
    endfunction

    // pick argument byte i of a frame holding n bytes
    function automatic logic [7:0] arg_byte(input logic [63:0] b, input logic [3:0] n, input int i);
        logic [63:0] s;
        s = b >> (8 * (int'(n) - 1 - i));
        arg_byte = s[7:0];
    endfunction

    // decimal digit to small value
    function automatic logic [2:0] digit(input logic [7:0] c);
        logic [7:0] d;
        d = c - `CH_DIGIT_0;
        digit = d[2:0];
    endfunction

    // =====================================================
    // pin synchronisers
    logic [1:0] link_up_s, link_err_s;
    logic [7:0] lvl_s1, lvl_s2;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link_up_s  <= 2'h0;
            link_err_s <= 2'h0;
            lvl_s1     <= 8'h00;
            lvl_s2     <= 8'h00;
        end else begin
            link_up_s  <= {link_up_s[0], link_up};
            link_err_s <= {link_err_s[0], link_err};
            lvl_s1     <= sig_level;
            lvl_s2     <= lvl_s1;
        end
    end
    wire link_ok = link_up_s[1] & ~link_err_s[1];

    // =====================================================
    // stored parameters
    logic [63:0] pw_r [4];
    logic [63:0] acode_r;
    logic [3:0]  attempts_r;
    logic [2:0]  act1_r [4], act2_r [4];
    logic [3:0]  two_level_r;
    logic [3:0]  act_valid_r;

    // =====================================================
    // command parser state
    station_cmd_pkg::mode_t mode_r;
    logic [7:0]  c0_r, c1_r;
    logic [1:0]  hdr_cnt_r;
    logic [63:0] buf_r;
    logic [3:0]  arg_cnt_r;
    logic        overrun_r, authed_r, acode_ok_r;
    logic        term_r;

    wire cmd_byte = (mode_r == station_cmd_pkg::MODE_COMMAND) && rx_valid;
    wire frame_end = cmd_byte && hdr_cnt_r == 2'h2 && rx_data == `CH_TERM;
    station_cmd_pkg::cmd_kind_t kind;
    assign kind = classify(c0_r, c1_r);
    wire [4:0] wr_item = 5'(c1_r - `CH_UPPER_A);
    wire secret_len = arg_cnt_r == 4'(`SECRET_BYTES) && !overrun_r;
    wire pw_match = secret_len && buf_r == pw_r[caller_station];
    wire may_write = caller_station == 2'h0 && acode_ok_r;
    wire [7:0] a0 = arg_byte(buf_r, arg_cnt_r, 0);
    wire [7:0] a1 = arg_byte(buf_r, arg_cnt_r, 1);
    wire [7:0] a2 = arg_byte(buf_r, arg_cnt_r, 2);
    wire [7:0] a3 = arg_byte(buf_r, arg_cnt_r, 3);
    wire accept = frame_end && (authed_r || kind == station_cmd_pkg::CK_AUTH);
    wire do_write = accept && kind == station_cmd_pkg::CK_WRITE && may_write && !overrun_r;

    // mode sequencing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_r   <= station_cmd_pkg::MODE_STANDBY;
            term_sel <= 1'b0;
        end else if (!link_ok) begin
            mode_r <= station_cmd_pkg::MODE_STANDBY;
        end else if (mode_r == station_cmd_pkg::MODE_STANDBY) begin
            mode_r <= station_cmd_pkg::MODE_COMMAND;
        end else if (accept && kind == station_cmd_pkg::CK_SWITCH && authed_r && arg_cnt_r != 4'h0) begin
            mode_r   <= station_cmd_pkg::MODE_TRANSPARENT;
            term_sel <= a0 != "1";
        end
    end
    assign mode = mode_r;

    // frame assembly: two code bytes, argument bytes, terminator
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            c0_r      <= 8'h00;
            c1_r      <= 8'h00;
            hdr_cnt_r <= 2'h0;
            buf_r     <= 64'h0;
            arg_cnt_r <= 4'h0;
            overrun_r <= 1'b0;
        end else if (mode_r != station_cmd_pkg::MODE_COMMAND || frame_end) begin
            hdr_cnt_r <= 2'h0;
            arg_cnt_r <= 4'h0;
            overrun_r <= 1'b0;
        end else if (cmd_byte) begin
            if (hdr_cnt_r == 2'h0) begin
                c0_r      <= rx_data;
                hdr_cnt_r <= 2'h1;
            end else if (hdr_cnt_r == 2'h1) begin
                c1_r      <= rx_data;
                hdr_cnt_r <= 2'h2;
            end else if (arg_cnt_r == 4'(`SECRET_BYTES)) begin
                overrun_r <= 1'b1;
            end else begin
                buf_r     <= {buf_r[55:0], rx_data};
                arg_cnt_r <= arg_cnt_r + 4'h1;
            end
        end
    end

    // session rights, cleared whenever the handler is in standby
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            authed_r   <= 1'b0;
            acode_ok_r <= 1'b0;
        end else if (mode_r == station_cmd_pkg::MODE_STANDBY) begin
            authed_r   <= 1'b0;
            acode_ok_r <= 1'b0;
        end else if (accept && kind == station_cmd_pkg::CK_AUTH) begin
            authed_r <= pw_match;
        end else if (accept && kind == station_cmd_pkg::CK_ACODE) begin
            acode_ok_r <= secret_len && buf_r == acode_r;
        end
    end

    // =====================================================
    // replies and events; transparent relay shares the output stage
    logic ok_reply;
    always_comb begin
        case (kind)
            station_cmd_pkg::CK_QUERY:  ok_reply = !overrun_r;
            station_cmd_pkg::CK_AUTH:   ok_reply = pw_match;
            station_cmd_pkg::CK_ACODE:  ok_reply = secret_len && buf_r == acode_r;
            station_cmd_pkg::CK_SWITCH: ok_reply = arg_cnt_r != 4'h0;
            station_cmd_pkg::CK_WRITE:  ok_reply = may_write && !overrun_r;
            default:                    ok_reply = 1'b0;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_valid      <= 1'b0;
            tx_data       <= 8'h00;
            term_tx_valid <= 1'b0;
            term_tx_data  <= 8'h00;
        end else if (mode_r == station_cmd_pkg::MODE_TRANSPARENT) begin
            tx_valid      <= term_rx_valid;
            tx_data       <= term_rx_data;
            term_tx_valid <= rx_valid;
            term_tx_data  <= rx_data;
        end else begin
            tx_valid      <= accept;
            tx_data       <= ok_reply ? `REPLY_ACK : `REPLY_NAK;
            term_tx_valid <= 1'b0;
        end
    end

    // query and write events for the parameter store
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            query_evt <= '0;
            write_evt <= '0;
        end else begin
            query_evt.valid <= accept && kind == station_cmd_pkg::CK_QUERY && !overrun_r;
            query_evt.item  <= 4'(c1_r - `CH_LOWER_A);
            write_evt.valid <= do_write;
            write_evt.item  <= wr_item;
            write_evt.args  <= {a0, a1, a2, a3};
        end
    end

    // error status: a new fault wins over a reset in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            err_status <= `ERR_CLEAR;
        else if (fault_set)
            err_status <= fault_code;
        else if (do_write && c1_r == "E")
            err_status <= `ERR_CLEAR;
    end

    // =====================================================
    // locally held parameters that steer the handler
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                pw_r[i]   <= {`SECRET_BYTES{`PW_RESET_BASE + 8'(i)}};
                act1_r[i] <= 3'h0;
                act2_r[i] <= 3'h0;
            end
            acode_r     <= `ACODE_RESET;
            attempts_r  <= `ATTEMPTS_RESET;
            two_level_r <= 4'h0;
            act_valid_r <= 4'h0;
        end else if (do_write) begin
            case (c1_r)
                "B": if (secret_len) pw_r[0] <= buf_r;
                "L": if (secret_len) acode_r <= buf_r;
                "I": if (arg_cnt_r != 4'h0 && digit(a0) != 3'h0) attempts_r <= 4'(digit(a0));
                "Q": if (arg_cnt_r >= 4'h2 && digit(a0) >= 3'h1 && digit(a0) <= 3'h4)
                         act_valid_r[2'(digit(a0) - 3'h1)] <= a1 == "1";
                "P": if (arg_cnt_r >= 4'h4 && digit(a0) >= 3'h1 && digit(a0) <= 3'h4) begin
                         two_level_r[2'(digit(a0) - 3'h1)] <= a1 == "2";
                         act1_r[2'(digit(a0) - 3'h1)]      <= digit(a2) > 3'h4 ? 3'h0 : digit(a2);
                         act2_r[2'(digit(a0) - 3'h1)]      <= digit(a3) > 3'h4 ? 3'h0 : digit(a3);
                     end
                default: ;
            endcase
        end
    end

    // =====================================================
    // signalling inputs: level class and change detection
    logic [1:0] cls_r [4];
    logic [3:0] seen_r, pending_r, chg;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_in
            logic [1:0] lvl, cls;
            assign lvl = lvl_s2[2*g +: 2];
            assign cls = two_level_r[g] ? {1'b0, lvl[1]} : lvl;
            assign chg[g] = seen_r[g] && cls != cls_r[g];
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    cls_r[g]  <= 2'h0;
                    seen_r[g] <= 1'b0;
                end else begin
                    cls_r[g]  <= cls;
                    seen_r[g] <= 1'b1;
                end
            end
        end
    endgenerate

    // =====================================================
    // one-second enable and call sequencer
    logic [25:0] sec_div_r;
    logic        sec_tick;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sec_div_r <= 26'h0;
            sec_tick  <= 1'b0;
        end else begin
            sec_tick  <= sec_div_r == 26'(SEC_CYCLES - 1);
            sec_div_r <= sec_div_r == 26'(SEC_CYCLES - 1) ? 26'h0 : sec_div_r + 26'h1;
        end
    end

    station_cmd_pkg::fax_state_t fx_r;
    logic [1:0]  cur_in_r;
    logic        phase_r, rerun_r;
    logic [3:0]  tries_r;
    logic [15:0] wait_r;
    logic [3:0]  trig, take;
    logic [2:0]  cur_act;
    assign trig = (do_write && c1_r == "R" && arg_cnt_r != 4'h0 && digit(a0) >= 3'h1 && digit(a0) <= 3'h4)
                  ? 4'(1 << (digit(a0) - 3'h1)) : 4'h0;
    assign cur_act = phase_r ? act2_r[cur_in_r] : act1_r[cur_in_r];
    wire act_ok = cur_act != 3'h0 && act_valid_r[2'(cur_act - 3'h1)];
    wire idle_pick = fx_r == station_cmd_pkg::FX_IDLE && pending_r != 4'h0;
    wire [1:0] first_pend = pending_r[0] ? 2'd0 : pending_r[1] ? 2'd1 : pending_r[2] ? 2'd2 : 2'd3;
    assign take = idle_pick ? 4'(1 << first_pend) : 4'h0;
    wire clr_inputs = do_write && c1_r == "S";
    wire clr_reps   = do_write && c1_r == "T";

    // pending events; a new change wins over its own clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            pending_r <= 4'h0;
        else
            pending_r <= (pending_r & ~take & ~(clr_inputs ? 4'hF : 4'h0)) | chg | trig;
    end

    // attempt, action and cycle sequencing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fx_r     <= station_cmd_pkg::FX_IDLE;
            cur_in_r <= 2'h0;
            phase_r  <= 1'b0;
            rerun_r  <= 1'b0;
            tries_r  <= 4'h0;
            wait_r   <= 16'h0;
            call     <= '0;
        end else if (clr_reps) begin
            fx_r     <= station_cmd_pkg::FX_IDLE;
            tries_r  <= 4'h0;
            rerun_r  <= 1'b0;
            call.req <= 1'b0;
        end else begin
            case (fx_r)
                station_cmd_pkg::FX_IDLE: if (idle_pick) begin
                    cur_in_r <= first_pend;
                    phase_r  <= 1'b0;
                    rerun_r  <= 1'b0;
                    tries_r  <= 4'h0;
                    fx_r     <= station_cmd_pkg::FX_CALL;
                end
                station_cmd_pkg::FX_CALL: if (act_ok && tries_r < attempts_r) begin
                    call.req      <= 1'b1;
                    call.action   <= 2'(cur_act - 3'h1);
                    call.input_no <= cur_in_r;
                    fx_r          <= station_cmd_pkg::FX_WAIT;
                end else if (!phase_r) begin
                    phase_r <= 1'b1;
                    tries_r <= 4'h0;
                end else if (!rerun_r) begin
                    wait_r <= 16'(WAIT_SEC);
                    fx_r   <= station_cmd_pkg::FX_PAUSE;
                end else begin
                    fx_r <= station_cmd_pkg::FX_IDLE;
                end
                station_cmd_pkg::FX_WAIT: if (call_done) begin
                    call.req <= 1'b0;
                    tries_r  <= tries_r + 4'h1;
                    fx_r     <= call_ok ? station_cmd_pkg::FX_IDLE : station_cmd_pkg::FX_CALL;
                end
                station_cmd_pkg::FX_PAUSE: if (sec_tick) begin
                    if (wait_r <= 16'h1) begin
                        phase_r <= 1'b0;
                        tries_r <= 4'h0;
                        rerun_r <= 1'b1;
                        fx_r    <= station_cmd_pkg::FX_CALL;
                    end else begin
                        wait_r <= wait_r - 16'h1;
                    end
                end
                default: fx_r <= station_cmd_pkg::FX_IDLE;
            endcase
        end
    end

endmodule

/* File: dv/station_cmd_assertions.sv */
// Purpose: port checks for the station command handler
// Assumes: one clock, rst async active high
// Notes:   attached by bind at the foot
`include "station_cmd_defines.svh"
module station_cmd_assertions (
    input wire logic                        clk,
    input wire logic                        rst,
    input wire logic                        link_up,
    input wire logic                        link_err,
    input wire logic                        rx_valid,
    input wire logic [7:0]                  rx_data,
    input wire logic                        tx_valid,
    input wire logic [7:0]                  tx_data,
    input wire logic                        term_rx_valid,
    input wire logic [7:0]                  term_rx_data,
    input wire logic                        term_tx_valid,
    input wire logic [7:0]                  term_tx_data,
    input wire station_cmd_pkg::mode_t      mode,
    input wire station_cmd_pkg::query_evt_t query_evt,
    input wire logic [7:0]                  fault_code,
    input wire logic                        fault_set,
    input wire logic [7:0]                  err_status,
    input wire station_cmd_pkg::call_req_t  call,
    input wire logic                        call_done
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================
    // link and mode sequences
    sequence link_ok_s; link_up && !link_err; endsequence
    sequence relay_s; mode == station_cmd_pkg::MODE_TRANSPARENT; endsequence
    enter_cmd_a:
        assert property (link_ok_s [*5] |-> mode != station_cmd_pkg::MODE_STANDBY) else $error("no command mode");
    link_drop_a:
        assert property (!link_up [*4] |-> mode == station_cmd_pkg::MODE_STANDBY) else $error("link drop kept mode");
    standby_quiet_a:
        assert property (mode == station_cmd_pkg::MODE_STANDBY [*2] |-> !tx_valid && !query_evt.valid)
        else $error("reply in standby");
    // ==========================================
    // relaying, the next cycle covers the register stage
    relay_down_a:
        assert property (relay_s ##0 rx_valid |=> term_tx_valid && term_tx_data == $past(rx_data))
        else $error("station byte not relayed");
    relay_up_a:
        assert property (relay_s ##0 term_rx_valid |=> tx_valid && tx_data == $past(term_rx_data))
        else $error("terminal byte not relayed");
    query_ack_a:
        assert property (query_evt.valid |-> tx_valid && tx_data == `REPLY_ACK && query_evt.item != 4'hF)
        else $error("query without ack");
    fault_hold_a:
        assert property (fault_set |=> err_status == $past(fault_code)) else $error("fault not stored");
    call_release_a:
        assert property (call.req && call_done |=> !call.req) else $error("call held after result");
endmodule
bind remote_station_command_handler station_cmd_assertions station_cmd_assertions_inst (.*);

/* File: dv/station_model.sv */
// Purpose: behavioural control station and fax line
// Assumes: send is called 1 ns after a rising edge
// Notes:   every fax call fails, so all retries are exercised
module station_model (
    input  wire logic                       clk,
    output logic                            rx_valid,
    output logic [7:0]                      rx_data,
    input  wire station_cmd_pkg::call_req_t call,
    output logic                            call_done,
    output logic                            call_ok
);
    timeunit 1ns;
    timeprecision 1ns;
    int n_calls = 0, wait_cnt = 0;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        call_done = 1'b0;
        call_ok = 1'b0;
    end
    // ==========================================
    // station frames, terminator optional
    task automatic send(string s, bit fin);
        for (int i = 0; i < s.len() + fin; i++) begin
            rx_data = (i < s.len()) ? s[i] : 8'h0D;
            rx_valid = 1'b1;
            @(posedge clk);
            #1;
        end
        rx_valid = 1'b0;
        rx_data = ~rx_data; // no stale byte on a released line
    endtask
    // ==========================================
    // fax line: slow answer, recipient never reached
    always @(posedge clk) begin
        #1;
        call_done = 1'b0;
        if (wait_cnt > 1) begin
            wait_cnt--;
        end else if (wait_cnt == 1) begin
            wait_cnt = 0;
            call_done = 1'b1;
        end else if (call.req === 1'b1) begin
            n_calls++;
            wait_cnt = 4;
        end
    end
endmodule

/* File: dv/tb_remote_station_command_handler.sv */
// Purpose: self-checking bench for the station command handler
// Assumes: small CLK_HZ and WAIT_MIN keep the call wait short
// Notes:   faxes fired by command, then by a level change
`include "station_cmd_defines.svh"
module tb_remote_station_command_handler;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rx_valid, tx_valid, term_tx_valid, term_sel, call_done, call_ok, rst = 1'b1;
    logic link_up = 1'b0, link_err = 1'b0, term_rx_valid = 1'b0, fault_set = 1'b0;
    logic [1:0] caller_station = 2'h0;
    logic [7:0] term_rx_data = 8'h00, fault_code = 8'h00, sig_level = 8'h00, rep = 8'h00;
    logic [7:0] rx_data, tx_data, term_tx_data, err_status;
    station_cmd_pkg::mode_t mode;
    station_cmd_pkg::query_evt_t query_evt, qev = '0;
    station_cmd_pkg::write_evt_t write_evt, wev = '0;
    station_cmd_pkg::call_req_t call;
    int n_mismatch = 0, cmp_count = 0;
    remote_station_command_handler #(.CLK_HZ(10), .WAIT_MIN(1)) remote_station_command_handler_inst (
        .clk(clk), .rst(rst), .link_up(link_up), .link_err(link_err), .caller_station(caller_station),
        .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
        .term_rx_valid(term_rx_valid), .term_rx_data(term_rx_data), .term_tx_valid(term_tx_valid),
        .term_tx_data(term_tx_data), .term_sel(term_sel), .mode(mode), .query_evt(query_evt),
        .write_evt(write_evt), .fault_code(fault_code), .fault_set(fault_set), .err_status(err_status),
        .sig_level(sig_level), .call(call), .call_done(call_done), .call_ok(call_ok));
    station_model station_model_inst (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .call(call),
        .call_done(call_done), .call_ok(call_ok));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ==========================================
    // shared compare, verdict and frame tasks
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // reply must show within four cycles, EE marks silence
    task automatic cmd(string s, logic [7:0] exp, string what);
        rep = 8'hEE;
        station_model_inst.send(s, 1'b1);
        for (int k = 0; k < 4; k++) begin
            if (tx_valid === 1'b1) begin
                rep = tx_data;
                qev = query_evt;
                wev = write_evt;
            end
            @(posedge clk);
            #1;
        end
        chk(what, exp, rep);
    endtask
    task automatic wait_mode(station_cmd_pkg::mode_t m);
        for (int k = 0; k < 20 && mode !== m; k++) begin
            @(posedge clk);
            #1;
        end
        chk("mode", 8'(m), 8'(mode));
        if (mode !== m) give_verdict();
    endtask
    // ==========================================
    // scenarios
    task automatic t_auth();
        cmd("?a", 8'hEE, "reply before password");
        cmd("$A12345678", `REPLY_NAK, "wrong password");
        cmd("$A11111111", `REPLY_ACK, "password");
    endtask
    task automatic t_query();
        string s = "?a";
        for (int i = 0; i < `QUERY_ITEMS; i++) begin
            s[1] = 8'(8'h61 + i);
            cmd(s, `REPLY_ACK, "query ack");
            chk("query item", 8'(i), {4'h0, qev.item});
        end
    endtask
    task automatic t_write();
        cmd("$C1", `REPLY_NAK, "write without code");
        cmd("$K00000000", `REPLY_ACK, "access code");
        cmd("$C1", `REPLY_ACK, "write with code");
        chk("write item", 8'h02, {3'h0, wev.item});
        caller_station = 2'h1;
        cmd("$C1", `REPLY_NAK, "write from second station");
        caller_station = 2'h0;
        cmd("$Z", `REPLY_NAK, "unknown code");
    endtask
    task automatic t_error();
        fault_code = 8'h5A;
        fault_set = 1'b1;
        @(posedge clk);
        #1;
        fault_set = 1'b0;
        chk("stored fault", 8'h5A, err_status);
        cmd("$E", `REPLY_ACK, "error reset");
        chk("cleared fault", `ERR_CLEAR, err_status);
    endtask
    // two actions, three tries each, one rerun after the wait
    task automatic t_fax();
        cmd("$Q11", `REPLY_ACK, "fax action");
        cmd("$P1211", `REPLY_ACK, "input actions");
        cmd("$R1", `REPLY_ACK, "fax trigger");
        repeat (1500) @(posedge clk);
        #1;
        chk("fax calls", 8'(4 * `ATTEMPTS_RESET), 8'(station_model_inst.n_calls));
        // input 1 in two-level mode: invalid must not count as a change
        sig_level = 8'h01;
        #200;
        chk("merged level", 8'(4 * `ATTEMPTS_RESET), 8'(station_model_inst.n_calls));
        sig_level = 8'h02;
        #200;
        chk("level call", 8'(4 * `ATTEMPTS_RESET + 1), 8'(station_model_inst.n_calls));
    endtask
    task automatic t_transp();
        cmd("$N1", `REPLY_ACK, "switch through");
        wait_mode(station_cmd_pkg::MODE_TRANSPARENT);
        chk("terminal select", 8'h00, {7'h0, term_sel});
        station_model_inst.send("Q", 1'b0);
        chk("to terminal", 8'h51, term_tx_data);
        term_rx_data = 8'hA5;
        term_rx_valid = 1'b1;
        @(posedge clk);
        #1;
        term_rx_valid = 1'b0;
        chk("to station", 8'hA5, tx_data);
        link_up = 1'b0;
        wait_mode(station_cmd_pkg::MODE_STANDBY);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        link_up = 1'b1;
        wait_mode(station_cmd_pkg::MODE_COMMAND);
        t_auth();
        t_query();
        t_write();
        t_error();
        t_fax();
        t_transp();
        link_up = 1'b1;
        wait_mode(station_cmd_pkg::MODE_COMMAND);
        link_err = 1'b1;
        wait_mode(station_cmd_pkg::MODE_STANDBY);
        give_verdict();
    end
endmodule
